// [core/ilp_pkg.sv]
package ilp_pkg;

  // ----------------------------------------------------------------
  // source numbering
  // ----------------------------------------------------------------
  // index = basic priority minus one; index 0 is reset, never handled here
  localparam int NSRC = 28;
  localparam int IDX_W = 5;
  localparam int LVL_W = 2;
  localparam int TRAP_IDX = 1;
  localparam int WDT_IDX = 3;
  localparam int FIRST_MASKABLE = 4;
  localparam int BYTE_W = 8;
  localparam int NBYTES = 4;

  typedef logic [NSRC-1:0] ilp_src_vec_t;
  typedef logic [IDX_W-1:0] ilp_idx_t;
  typedef logic [LVL_W-1:0] ilp_lvl_t;

  // bits 0..2 carry no latch: reset, both traps, unused slot
  localparam ilp_src_vec_t IL_IMPL_MASK = 28'hFFFFFF8;
  // bits 2 and 3 are hardware-clear only
  localparam ilp_src_vec_t IL_SW_CLR_MASK = 28'hFFFFFF0;
  localparam ilp_src_vec_t EF_MASK = 28'hFFFFFF0;
  localparam ilp_src_vec_t SRC_ZERO = 28'h0000000;

  // ----------------------------------------------------------------
  // special-function addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  typedef logic [ADDR_W-1:0] ilp_addr_t;
  localparam ilp_addr_t IL_LOW_ADDR = 12'hFE0;
  localparam ilp_addr_t IL_HIGH_ADDR = 12'hFE1;
  localparam ilp_addr_t IL_EXT_ADDR = 12'hFE2;
  localparam ilp_addr_t IL_TOP_ADDR = 12'hFE3;
  localparam ilp_addr_t EIR_LOW_ADDR = 12'h03A;
  localparam int IMF_BIT = 0;

  // ----------------------------------------------------------------
  // vectors
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_TOP = 16'hFFFE;
  localparam logic [15:0] VEC_RELOC_TOP = 16'h01FE;
  localparam logic [15:0] VEC_OPTION_LO = 16'hFFFA;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage

// [core/ilp_arb.sv]
`timescale 1ns/100ps
module ilp_arb (
  input logic [ilp_pkg::NSRC-1:0] pend_i,
  input logic [ilp_pkg::NSRC*ilp_pkg::LVL_W-1:0] level_i,
  output logic valid_o,
  output logic [ilp_pkg::IDX_W-1:0] idx_o
);
  import ilp_pkg::*;

  // ----------------------------------------------------------------
  // level compare, then basic priority
  // ----------------------------------------------------------------
  // smaller level value is more urgent; on a tie the lower index wins,
  // so the scan runs downward and replaces on less-or-equal
  ilp_lvl_t best_lvl;
  ilp_lvl_t cur_lvl;

  always_comb begin
    valid_o = 1'b0;
    idx_o = '0;
    best_lvl = '1;
    cur_lvl = '0;
    for (int i = NSRC - 1; i >= FIRST_MASKABLE; i--) begin
      cur_lvl = level_i[i*LVL_W +: LVL_W];
      if (pend_i[i] && (!valid_o || cur_lvl <= best_lvl)) begin
        valid_o = 1'b1;
        best_lvl = cur_lvl;
        idx_o = IDX_W'(i);
      end
    end
  end

endmodule

// [core/ilp_ctrl.sv]
`timescale 1ns/100ps
// Functional notes
// - 27 sources; swi, undef, watchdog non-maskable
// - accepting again after enable allows nesting
// - request sets latch; asks cpu if enabled
// - maskable needs master and own flag
// - order by programmable level, then basic priority
// - no ordering among non-maskable sources; the code takes the trap before the watchdog
// - vectors step down by two, relocatable
// - ram vectors need relocate and ram select
// - 0xFFFA and 0xFFFB never used as vectors
// - both traps have no request latch
// - latch clears when cpu accepts it
// - reset clears every request latch
// - latches readable at 0x0FE0 to 0x0FE3
// - writing zero clears only that latch
// - positions 2 and 3 ignore software writes
// - writing one never sets a latch
// - master flag already zero on entry
// - word read: low register, then next register
// - accept stacks and clears master flag; return restores
// - reset clears master and per-source flags
// - low register bits 0 to 2 read zero
module ilp_ctrl (
  input logic core_clk_i,
  input logic reset_i,
  input logic [ilp_pkg::NSRC-1:0] src_req_i,
  input logic trap_req_i,
  input logic [ilp_pkg::NSRC*ilp_pkg::LVL_W-1:0] prio_level_i,
  input logic vector_relocate_i,
  input logic vector_ram_select_i,
  input logic [ilp_pkg::ADDR_W-1:0] sfr_addr_i,
  input logic sfr_wr_i,
  input logic [7:0] sfr_wdata_i,
  input logic sfr_rd_i,
  output logic [15:0] sfr_rdata_o,
  input logic irq_ack_i,
  input logic enable_accept_op_i,
  input logic disable_accept_op_i,
  input logic return_op_i,
  input logic ret_imf_i,
  output logic irq_req_o,
  output logic irq_nmi_o,
  output logic [ilp_pkg::IDX_W-1:0] irq_source_o,
  output logic [15:0] irq_vector_o,
  output logic vector_in_ram_o,
  output logic master_accept_flag_o,
  output logic imf_stacked_o
);
  import ilp_pkg::*;
  // latch and flag vectors padded to whole bytes for byte-wide access
  localparam int WORD_W = NBYTES * BYTE_W;

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  // used for both bytes of a word read
  function automatic logic [7:0] reg_byte(
    input ilp_addr_t addr,
    input ilp_src_vec_t il,
    input ilp_src_vec_t ef,
    input logic master_accept_flag
  );
    logic [7:0] res;
    res = BYTE_ZERO;
    for (int k = 0; k < NBYTES; k++) begin
      if (addr == IL_LOW_ADDR + ADDR_W'(k)) begin
        res = BYTE_W'(WORD_W'(il) >> (k * BYTE_W));
      end
      if (addr == EIR_LOW_ADDR + ADDR_W'(k)) begin
        res = BYTE_W'(WORD_W'(ef) >> (k * BYTE_W));
      end
    end
    if (addr == EIR_LOW_ADDR) begin
      res[IMF_BIT] = master_accept_flag;
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ilp_src_vec_t il_q, il_d;
  ilp_src_vec_t ef_q, ef_d;
  logic imf_q, imf_d;
  logic stk_q, stk_d;
  logic [15:0] rdata_q, rdata_d;
  logic req_q, req_d;
  logic nmi_q, nmi_d;
  ilp_idx_t src_q, src_d;
  logic [15:0] vec_q, vec_d;
  logic ram_q, ram_d;

  ilp_src_vec_t set_hw;
  ilp_src_vec_t clr_sw;
  ilp_src_vec_t clr_ack;
  ilp_src_vec_t pend_w;
  logic arb_valid;
  ilp_idx_t arb_idx;
  logic cand_valid;
  logic cand_nmi;
  ilp_idx_t cand_idx;
  logic [WORD_W-1:0] clr_wide, ef_wide;

  // ----------------------------------------------------------------
  // request latches
  // ----------------------------------------------------------------
  // a read-modify-write by software can still wipe a request that
  // arrived between its read and write; plain writes avoid that
  always_comb begin
    set_hw = src_req_i & IL_IMPL_MASK;
    clr_wide = '0;
    for (int k = 0; k < NBYTES; k++) begin
      if (sfr_wr_i && sfr_addr_i == IL_LOW_ADDR + ADDR_W'(k)) begin
        clr_wide[k*BYTE_W +: BYTE_W] = ~sfr_wdata_i;
      end
    end
    clr_sw = ilp_src_vec_t'(clr_wide) & IL_SW_CLR_MASK;
    clr_ack = SRC_ZERO;
    if (irq_ack_i && req_q && src_q != ilp_idx_t'(TRAP_IDX)) begin
      clr_ack[src_q] = 1'b1;
    end
    // set after clear so a same-cycle request survives
    il_d = ((il_q & ~clr_sw & ~clr_ack) | set_hw) & IL_IMPL_MASK;
  end

  // ----------------------------------------------------------------
  // accept flags
  // ----------------------------------------------------------------
  always_comb begin
    ef_wide = WORD_W'(ef_q);
    for (int k = 0; k < NBYTES; k++) begin
      if (sfr_wr_i && sfr_addr_i == EIR_LOW_ADDR + ADDR_W'(k)) begin
        ef_wide[k*BYTE_W +: BYTE_W] = sfr_wdata_i;
      end
    end
    ef_d = ilp_src_vec_t'(ef_wide) & EF_MASK;
    imf_d = imf_q;
    stk_d = stk_q;
    if (sfr_wr_i && sfr_addr_i == EIR_LOW_ADDR) begin
      imf_d = sfr_wdata_i[IMF_BIT];
    end
    if (enable_accept_op_i) begin
      imf_d = 1'b1;
    end
    if (disable_accept_op_i) begin
      imf_d = 1'b0;
    end
    if (return_op_i) begin
      imf_d = ret_imf_i;
    end
    // acceptance outranks everything: the flag is stacked then cleared
    if (irq_ack_i && req_q) begin
      stk_d = imf_q;
      imf_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  assign pend_w = il_q & ef_q & {NSRC{imf_q}};

  ilp_arb u_arb (
    .pend_i(pend_w),
    .level_i(prio_level_i),
    .valid_o(arb_valid),
    .idx_o(arb_idx)
  );

  // the traps are instruction-synchronous and share one vector, so
  // taking them before the watchdog imposes no real ordering
  always_comb begin
    cand_valid = 1'b1;
    cand_nmi = 1'b1;
    cand_idx = ilp_idx_t'(TRAP_IDX);
    if (trap_req_i) begin
      cand_idx = ilp_idx_t'(TRAP_IDX);
    end else if (il_q[WDT_IDX]) begin
      cand_idx = ilp_idx_t'(WDT_IDX);
    end else begin
      cand_nmi = 1'b0;
      cand_valid = arb_valid;
      cand_idx = arb_idx;
    end
  end

  // ----------------------------------------------------------------
  // cpu-facing outputs
  // ----------------------------------------------------------------
  // drop the request for the cycle after an acceptance so the cpu never
  // sees the source it just took while its latch is clearing
  always_comb begin
    req_d = cand_valid && !(irq_ack_i && req_q);
    nmi_d = cand_nmi;
    src_d = cand_idx;
    // bit 2 has no source, so 0xFFFA never comes out
    vec_d = (vector_relocate_i ? VEC_RELOC_TOP : VEC_TOP)
            - (16'(cand_idx) << 1);
    ram_d = vector_relocate_i && vector_ram_select_i;
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd_i) begin
      rdata_d = {reg_byte(sfr_addr_i + ADDR_W'(1), il_q, ef_q, imf_q),
                 reg_byte(sfr_addr_i, il_q, ef_q, imf_q)};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      il_q <= SRC_ZERO;
      ef_q <= SRC_ZERO;
      imf_q <= 1'b0;
      stk_q <= 1'b0;
      rdata_q <= RDATA_RST;
      req_q <= 1'b0;
      nmi_q <= 1'b0;
      src_q <= '0;
      vec_q <= VEC_TOP;
      ram_q <= 1'b0;
    end else begin
      il_q <= il_d;
      ef_q <= ef_d;
      imf_q <= imf_d;
      stk_q <= stk_d;
      rdata_q <= rdata_d;
      req_q <= req_d;
      nmi_q <= nmi_d;
      src_q <= src_d;
      vec_q <= vec_d;
      ram_q <= ram_d;
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign irq_req_o = req_q;
  assign irq_nmi_o = nmi_q;
  assign irq_source_o = src_q;
  assign irq_vector_o = vec_q;
  assign vector_in_ram_o = ram_q;
  assign master_accept_flag_o = imf_q;
  assign imf_stacked_o = stk_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_accept;
    irq_ack_i && irq_req_o && !return_op_i;
  endsequence

  sequence s_stacked;
    !master_accept_flag_o && imf_stacked_o == $past(master_accept_flag_o);
  endsequence

  property p_latch_set;
    (|set_hw) |=> ((il_q & $past(set_hw)) == $past(set_hw));
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("request did not set its latch");

  property p_ack_clear;
    s_accept ##0 (!irq_nmi_o || irq_source_o == ilp_idx_t'(WDT_IDX))
      ##0 !src_req_i[irq_source_o] |=> !il_q[$past(irq_source_o)];
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("accepted latch not cleared");

  property p_no_sw_set;
    !(|src_req_i) |=> ((il_q & ~$past(il_q)) == SRC_ZERO);
  endproperty
  a_no_sw_set: assert property (p_no_sw_set)
    else $error("latch set without a request");

  property p_wdt_hold;
    sfr_wr_i && sfr_addr_i == IL_LOW_ADDR && il_q[WDT_IDX]
      && !irq_ack_i |=> il_q[WDT_IDX];
  endproperty
  a_wdt_hold: assert property (p_wdt_hold)
    else $error("watchdog latch cleared by software");

  property p_sw_clear;
    sfr_wr_i && sfr_addr_i == IL_HIGH_ADDR && !(|src_req_i)
      && !irq_ack_i |=> il_q[15:8] == $past(il_q[15:8] & sfr_wdata_i)
      && il_q[7:0] == $past(il_q[7:0]);
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("software clear touched wrong bits");

  property p_reset_vals;
    $fell(reset_i) |-> il_q == SRC_ZERO && ef_q == SRC_ZERO && !imf_q;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("flags not clear after reset");

  property p_mask_gate;
    irq_req_o && !irq_nmi_o |-> $past(imf_q)
      && (|($past(ef_q & il_q) & (ilp_src_vec_t'(1) << irq_source_o)));
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("maskable request raised while masked");

  property p_accept_imf;
    s_accept |=> s_stacked ##0 !irq_req_o;
  endproperty
  a_accept_imf: assert property (p_accept_imf)
    else $error("master flag not stacked and cleared");

  property p_return;
    return_op_i && !(irq_ack_i && irq_req_o) |=>
      master_accept_flag_o == $past(ret_imf_i);
  endproperty
  a_return: assert property (p_return)
    else $error("return did not restore master flag");

  property p_vector;
    irq_req_o |-> irq_vector_o != VEC_OPTION_LO
      && irq_vector_o == ($past(vector_relocate_i) ? VEC_RELOC_TOP
      : VEC_TOP) - (16'(irq_source_o) << 1);
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector does not match source");

  property p_trap;
    trap_req_i && !(irq_ack_i && irq_req_o) |=> irq_req_o
      && irq_nmi_o && irq_source_o == ilp_idx_t'(TRAP_IDX);
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap not presented");

  property p_read_pair;
    sfr_rd_i && sfr_addr_i == IL_LOW_ADDR |=> sfr_rdata_o[2:0] == 3'h0
      && sfr_rdata_o[7:3] == $past(il_q[7:3])
      && sfr_rdata_o[15:8] == $past(il_q[15:8]);
  endproperty
  a_read_pair: assert property (p_read_pair)
    else $error("latch word read wrong");

  property p_ram;
    vector_relocate_i && vector_ram_select_i |=> vector_in_ram_o;
  endproperty
  a_ram: assert property (p_ram)
    else $error("ram vector select missed");

endmodule

// [dv/ilp_cpu_model.sv]
`timescale 1ns/100ps
// ----
// cpu side: takes a presented request after a short wait
// ----
module ilp_cpu_model (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic irq_req_i,
  input wire logic run_i,
  input wire logic [3:0] wait_i,
  output logic irq_ack_o
);
  logic [3:0] cnt_q;
  // restart after every ack so two acks never come closer than two cycles
  always_ff @(posedge core_clk_i) begin
    if (reset_i || irq_ack_o || !irq_req_i || !run_i) begin
      cnt_q <= 4'h0;
      irq_ack_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      irq_ack_o <= (cnt_q >= wait_i);
    end
  end
endmodule

// [dv/interrupt_latch_priority_ctrl_test.sv]
`timescale 1ns/100ps
module interrupt_latch_priority_ctrl_test;
  import ilp_pkg::*;
  logic clk, rst, trap, reloc, ram, wr_s, rd_s, ack, ei, di, ret, rimf;
  logic run, req, nmi, inram, imf_o, stk_o;
  logic [27:0] src;
  logic [55:0] lvl;
  logic [11:0] addr;
  logic [7:0] wd;
  logic [15:0] rdata, vec, m_vec;
  logic [4:0] srcx;
  logic [3:0] cw;
  logic [63:0] lv;
  bit [27:0] m_il, m_ef;
  bit m_imf, m_stk, m_ram, m_req;
  int errors, n_tests, cyc, m_src;

  ilp_ctrl DUT (.core_clk_i(clk), .reset_i(rst), .src_req_i(src),
    .trap_req_i(trap), .prio_level_i(lvl), .vector_relocate_i(reloc),
    .vector_ram_select_i(ram), .sfr_addr_i(addr), .sfr_wr_i(wr_s),
    .sfr_wdata_i(wd), .sfr_rd_i(rd_s), .sfr_rdata_o(rdata),
    .irq_ack_i(ack), .enable_accept_op_i(ei), .disable_accept_op_i(di),
    .return_op_i(ret), .ret_imf_i(rimf), .irq_req_o(req),
    .irq_nmi_o(nmi), .irq_source_o(srcx), .irq_vector_o(vec),
    .vector_in_ram_o(inram), .master_accept_flag_o(imf_o),
    .imf_stacked_o(stk_o));
  ilp_cpu_model CPU (.core_clk_i(clk), .reset_i(rst), .irq_req_i(req),
    .run_i(run), .wait_i(cw), .irq_ack_o(ack));

  // ----
  // reference model
  // ----
  function automatic int win();
    int b;
    b = -1;
    if (trap) return TRAP_IDX;
    if (m_il[WDT_IDX]) return WDT_IDX;
    if (!m_imf) return -1;
    for (int i = FIRST_MASKABLE; i < NSRC; i++)
      if (m_il[i] && m_ef[i] && (b < 0 || lvl[2*i+:2] < lvl[2*b+:2])) b = i;
    return b;
  endfunction

  function automatic logic [7:0] rb(input logic [11:0] a);
    case (a)
      IL_LOW_ADDR: return {m_il[7:3], 3'h0};
      IL_HIGH_ADDR: return m_il[15:8];
      IL_EXT_ADDR: return m_il[23:16];
      IL_TOP_ADDR: return {4'h0, m_il[27:24]};
      EIR_LOW_ADDR: return {m_ef[7:4], 3'h0, m_imf};
      12'h03B: return m_ef[15:8];
      12'h03C: return m_ef[23:16];
      12'h03D: return {4'h0, m_ef[27:24]};
      default: return 8'h00;
    endcase
  endfunction

  always @(posedge clk) begin
    int w;
    bit o, acc;
    bit [31:0] c, e;
    bit [27:0] a;
    w = win();
    o = m_imf;
    acc = ack && m_req;
    c = 32'h0;
    a = 28'h0;
    e = {4'h0, m_ef};
    if (wr_s && addr[11:2] == IL_LOW_ADDR[11:2]) c[addr[1:0]*8+:8] = ~wd;
    if (wr_s && addr >= EIR_LOW_ADDR && addr < EIR_LOW_ADDR + 12'h4)
      e[(addr - EIR_LOW_ADDR)*8+:8] = wd;
    if (wr_s && addr == EIR_LOW_ADDR) m_imf = wd[0];
    if (ei) m_imf = 1'b1;
    if (di) m_imf = 1'b0;
    if (ret) m_imf = rimf;
    if (acc) begin
      m_stk = o;
      m_imf = 1'b0;
      if (m_src > 2) a[m_src] = 1'b1;
    end
    m_ef = e[27:0] & EF_MASK;
    // a request wins over a clear landing on the same edge
    m_il = (m_il & ~(c[27:0] & IL_SW_CLR_MASK) & ~a) | (src & IL_IMPL_MASK);
    m_ram = reloc & ram;
    // the presented request lags the latches by one register stage
    m_req = (w >= 0) && !acc;
    m_src = w;
    m_vec = (reloc ? VEC_RELOC_TOP : VEC_TOP) - 16'(2 * w);
    if (rst) begin
      {m_il, m_ef, m_imf, m_stk, m_ram, m_req} = '0;
    end
  end

  // ----
  // checking
  // ----
  task automatic chk(input string n, input logic [15:0] s,
      input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task finish_test;
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(negedge clk) begin
    if (!rst) begin
      chk("flag", imf_o, m_imf);
      chk("stacked", stk_o, m_stk);
      chk("in_ram", inram, m_ram);
      chk("req", req, m_req);
    end
    if (!rst && m_req) begin
      chk("source", srcx, 16'(m_src));
      chk("vector", vec, m_vec);
      chk("nmi", nmi, m_src < FIRST_MASKABLE);
      chk("option", vec[15:1] == VEC_OPTION_LO[15:1], 1'b0);
    end
  end

  // ----
  // bus and op drivers
  // ----
  task automatic wb(input logic [11:0] a, input logic [7:0] d,
      input logic [27:0] s);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    src <= s;
    @(posedge clk);
    wr_s <= 1'b0;
    src <= 28'h0;
  endtask

  task automatic rw(input logic [11:0] a);
    logic [15:0] x;
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    // expected word is what the latches hold at the read edge
    @(negedge clk);
    x = {rb(a + 12'h1), rb(a)};
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk("read", rdata, x);
  endtask

  task automatic opx(input int k);
    @(posedge clk);
    {ret, di, ei} <= 3'(1 << k);
    @(posedge clk);
    {ret, di, ei} <= 3'h0;
  endtask

  task automatic wack;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!ack && k < 40);
    chk("ack", ack, 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      finish_test;
    end
  end

  // ----
  // scenarios
  // ----
  initial begin
    {rst, run} = 2'h3;
    {trap, reloc, ram, wr_s, rd_s, ei, di, ret, rimf} = '0;
    {src, lvl, addr, wd} = '0;
    cw = 4'h1;
    void'($urandom(81603));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rw(IL_LOW_ADDR);
    rw(IL_EXT_ADDR);
    rw(EIR_LOW_ADDR);
    rw(12'h100);
    wb(12'h000, 8'h00, 28'h0000020);
    repeat (4) @(negedge clk);
    chk("req", req, 1'b0);
    rw(IL_LOW_ADDR);
    wb(12'h000, 8'h00, 28'h0000008);
    wack;
    rw(IL_LOW_ADDR);
    // hold the cpu off so the watchdog latch stays up under writes
    run <= 1'b0;
    wb(12'h000, 8'h00, 28'h0000008);
    wb(IL_LOW_ADDR, 8'h00, 28'h0);
    rw(IL_LOW_ADDR);
    wb(IL_HIGH_ADDR, 8'hFF, 28'h0);
    wb(IL_TOP_ADDR, 8'hFF, 28'h0);
    wb(IL_HIGH_ADDR, 8'h00, 28'h0000200);
    rw(IL_LOW_ADDR);
    rw(IL_TOP_ADDR);
    run <= 1'b1;
    wack;
    for (int t = 0; t < 6; t++) begin
      opx(1);
      for (int b = 1; b < 4; b++)
        wb(EIR_LOW_ADDR + 12'(b), 8'($urandom), 28'h0);
      wb(EIR_LOW_ADDR, 8'($urandom) & 8'hF0, 28'h0);
      lv = {$urandom, $urandom};
      lvl <= lv[55:0];
      cw <= 4'(1 + $urandom_range(2));
      wb(12'h000, 8'h00, 28'($urandom));
      rw(EIR_LOW_ADDR);
      rw(IL_EXT_ADDR);
      for (int k = 0; k < 26; k++) begin
        @(negedge clk);
        if ((m_il & m_ef) == 28'h0) break;
        opx(0);
        wack;
      end
      for (int b = 0; b < 4; b++)
        wb(IL_LOW_ADDR + 12'(b), 8'h00, 28'h0);
      rw(IL_HIGH_ADDR);
    end
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      {reloc, ram} <= 2'(r);
      trap <= 1'b1;
      wb(12'h000, 8'h00, 28'h0000008);
      wack;
      trap <= 1'b0;
      wack;
      rimf <= r[0];
      opx(2);
    end
    repeat (3) @(posedge clk);
    finish_test;
  end
endmodule
